// ---- verilog/ssc_map.svh ----
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
// Device register offsets and reset values.
`define SSC_OFS_OBSERVE   8'h00
`define SSC_OFS_PD_MASK   8'h01
`define SSC_OFS_OVERRIDE  8'h02
`define SSC_OFS_SLAVE_CTL 8'h06
`define SSC_OFS_DIG_CTL   8'h07
`define SSC_RST_PD_MASK   8'h00
`define SSC_RST_OVERRIDE  8'h00
`define SSC_RST_SLAVE_CTL 8'h10
`define SSC_RST_DIG_CTL   8'h01
// Field positions.
`define SSC_BIT_LOAD_DONE 2
`define SSC_BIT_PD_OVR    0
`define SSC_BIT_RXD_VAL   6
`define SSC_BIT_RXD_OVR   7
`define SSC_BIT_REG_EN    3
`define SSC_BIT_SOFT_RST  6
// Seven-bit slave address with every strap low; the strap value adds to it.
`define SSC_ADDR_BASE     7'h58
// Host command registers.
`define SSC_H_CTRL        3'h0
`define SSC_H_SLAVE       3'h1
`define SSC_H_REG         3'h2
`define SSC_H_WDATA       3'h3
`define SSC_H_STATUS      3'h4
`define SSC_H_RDATA       3'h5
// Timing, in nanoseconds and in cycles of the 100 ns clock.
`define SSC_CLK_NS        100
`define SSC_T_BUF_NS      4700
`define SSC_T_HIGH_NS     50000
`define SSC_SCL_NS        800
`define SSC_BUF_CYC       ((`SSC_T_BUF_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)
`define SSC_HIGH_CYC      (`SSC_T_HIGH_NS / `SSC_CLK_NS)
`define SSC_QTR_CYC       (`SSC_SCL_NS / 4 / `SSC_CLK_NS)
`endif

// ---- verilog/ssc_pkg.sv ----
package ssc_pkg;
  typedef enum logic [7:0] {
    SSC_D_IDLE  = 8'h01,
    SSC_D_ADDR  = 8'h02,
    SSC_D_REG   = 8'h04,
    SSC_D_DATA  = 8'h08,
    SSC_D_ACK   = 8'h10,
    SSC_D_TX    = 8'h20,
    SSC_D_TXACK = 8'h40,
    SSC_D_SKIP  = 8'h80
  } ssc_dev_state_t;
  typedef enum logic [4:0] {
    SSC_H_IDLE  = 5'h01,
    SSC_H_START = 5'h02,
    SSC_H_TX    = 5'h04,
    SSC_H_RX    = 5'h08,
    SSC_H_STOP  = 5'h10
  } ssc_host_state_t;
endpackage : ssc_pkg

// ---- verilog/ssc_if.sv ----
`timescale 1ns/1ps
interface ssc_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Open-drain wires with pull-ups: low whenever any enabled driver pulls low.
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface : ssc_if

// ---- verilog/ssc_dev.sv ----
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module ssc_dev
  import ssc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  ssc_if.dev              bus,
  input  wire logic       serial_mode_strap,
  input  wire logic [3:0] addr_strap,
  input  wire logic       config_load_done,
  input  wire logic       power_down_pin,
  input  wire logic       rx_detect_reset_auto,
  output logic      [7:0] channel_power_down,
  output logic            rx_detect_reset,
  output logic            swing_eq_write_enable,
  output logic            bus_idle
);
  `include "ssc_map.svh"

  //////////////////////////////////////////////////////////////////////////////
  logic           scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic           sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic [3:0]     strap_s1_ff, strap_s2_ff;
  logic           mode_s1_ff, mode_s2_ff;
  logic           pdpin_s1_ff, pdpin_s2_ff;
  ssc_dev_state_t state_ff, nxt_state, target_ff, nxt_target;
  logic [3:0]     cnt_ff, nxt_cnt;
  logic [7:0]     shift_ff, nxt_shift;
  logic [7:0]     reg_addr_ff, nxt_reg_addr;
  logic           oe_ff, nxt_oe;
  logic           wr_en;
  logic [2:0]     obs_rsv_ff;
  logic [7:0]     pd_mask_ff, override_ff, slave_ctl_ff, dig_ctl_ff;
  logic [9:0]     hi_cnt_ff;
  logic           after_stop_ff;
  logic [7:0]     channel_power_down_ff;
  logic           rx_detect_reset_ff, swing_eq_write_enable_ff, bus_idle_ff;

  // Strap sampling.
  // Straps pass two flops; the pads' pull-downs make a floating strap read 0000.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
      {strap_s1_ff, strap_s2_ff}       <= 8'h00;
      {mode_s1_ff, mode_s2_ff}         <= 2'h0;
      {pdpin_s1_ff, pdpin_s2_ff}       <= 2'h0;
    end
    else
    begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {bus.scl, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {bus.sda, sda_s1_ff, sda_s2_ff};
      {strap_s1_ff, strap_s2_ff}       <= {addr_strap, strap_s1_ff};
      {mode_s1_ff, mode_s2_ff}         <= {serial_mode_strap, mode_s1_ff};
      {pdpin_s1_ff, pdpin_s2_ff}       <= {power_down_pin, pdpin_s1_ff};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  wire scl_rise = scl_s2_ff && !scl_d_ff;
  wire scl_fall = !scl_s2_ff && scl_d_ff;
  wire start_det = scl_s2_ff && scl_d_ff && sda_d_ff && !sda_s2_ff;
  wire stop_det = scl_s2_ff && scl_d_ff && !sda_d_ff && sda_s2_ff;
  wire [7:0] rx_byte = {shift_ff[6:0], sda_s2_ff};
  wire [6:0] my_addr = `SSC_ADDR_BASE + {3'h0, strap_s2_ff};
  wire addr_hit = mode_s2_ff && (rx_byte[7:1] == my_addr);
  wire both_high = scl_s2_ff && sda_s2_ff;
  wire buf_done  = after_stop_ff && (hi_cnt_ff > 10'(`SSC_BUF_CYC));
  wire high_done = hi_cnt_ff > 10'(`SSC_HIGH_CYC);

  // Read decode of the register map.
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == `SSC_OFS_OBSERVE)
      r = {obs_rsv_ff[2], strap_s2_ff, config_load_done, obs_rsv_ff[1:0]};
    else if (a == `SSC_OFS_PD_MASK)
      r = pd_mask_ff;
    else if (a == `SSC_OFS_OVERRIDE)
      r = override_ff;
    else if (a == `SSC_OFS_SLAVE_CTL)
      r = slave_ctl_ff;
    else if (a == `SSC_OFS_DIG_CTL)
      r = dig_ctl_ff;
    return r;
  endfunction : read_reg

  wire [7:0] rd_byte = read_reg(reg_addr_ff);

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_target   = target_ff;
    nxt_cnt      = cnt_ff;
    nxt_shift    = shift_ff;
    nxt_reg_addr = reg_addr_ff;
    nxt_oe       = oe_ff;
    wr_en        = 1'b0;
    if (start_det)
    begin
      nxt_state = SSC_D_ADDR;
      nxt_cnt   = 4'h0;
      nxt_oe    = 1'b0;
    end
    else if (stop_det || high_done)
    begin
      nxt_state = SSC_D_IDLE;
      nxt_oe    = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        SSC_D_IDLE, SSC_D_SKIP:
        begin
          nxt_oe = 1'b0;
        end
        SSC_D_ADDR, SSC_D_REG, SSC_D_DATA:
        begin
          if (scl_rise)
          begin
            nxt_shift = rx_byte;
            nxt_cnt   = cnt_ff + 4'h1;
            if (cnt_ff == 4'h7)
            begin
              nxt_state = SSC_D_ACK;
              if (state_ff == SSC_D_ADDR)
              begin
                if (!addr_hit)
                  nxt_state = SSC_D_SKIP;
                nxt_target = rx_byte[0] ? SSC_D_TX : SSC_D_REG;
              end
              else if (state_ff == SSC_D_REG)
              begin
                nxt_reg_addr = rx_byte;
                nxt_target   = SSC_D_DATA;
              end
              else
              begin
                wr_en      = 1'b1;
                nxt_target = SSC_D_SKIP;
              end
            end
          end
        end
        // Drive changes only on clock fall.
        SSC_D_ACK:
        begin
          if (scl_fall)
          begin
            if (!oe_ff)
              nxt_oe = 1'b1;
            else
            begin
              nxt_state = target_ff;
              nxt_cnt   = 4'h0;
              nxt_oe    = 1'b0;
              if (target_ff == SSC_D_TX)
              begin
                nxt_oe    = !rd_byte[7];
                nxt_shift = {rd_byte[6:0], 1'b0};
              end
            end
          end
        end
        SSC_D_TX:
        begin
          if (scl_rise)
            nxt_cnt = cnt_ff + 4'h1;
          if (scl_fall)
          begin
            if (cnt_ff == 4'h8)
            begin
              nxt_oe    = 1'b0;
              nxt_state = SSC_D_TXACK;
            end
            else
            begin
              nxt_oe    = !shift_ff[7];
              nxt_shift = {shift_ff[6:0], 1'b0};
            end
          end
        end
        SSC_D_TXACK:
        begin
          if (scl_rise)
            nxt_state = SSC_D_SKIP;
        end
        default:
        begin
          nxt_state = SSC_D_IDLE;
          nxt_oe    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff    <= SSC_D_IDLE;
      target_ff   <= SSC_D_IDLE;
      cnt_ff      <= 4'h0;
      shift_ff    <= 8'h00;
      reg_addr_ff <= 8'h00;
      oe_ff       <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      target_ff   <= nxt_target;
      cnt_ff      <= nxt_cnt;
      shift_ff    <= nxt_shift;
      reg_addr_ff <= nxt_reg_addr;
      oe_ff       <= nxt_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  wire soft_rst = wr_en && (reg_addr_ff == `SSC_OFS_DIG_CTL) && rx_byte[`SSC_BIT_SOFT_RST];

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      obs_rsv_ff   <= 3'h0;
      pd_mask_ff   <= `SSC_RST_PD_MASK;
      override_ff  <= `SSC_RST_OVERRIDE;
      slave_ctl_ff <= `SSC_RST_SLAVE_CTL;
      dig_ctl_ff   <= `SSC_RST_DIG_CTL;
    end
    else if (soft_rst)
    begin
      obs_rsv_ff   <= 3'h0;
      pd_mask_ff   <= `SSC_RST_PD_MASK;
      override_ff  <= `SSC_RST_OVERRIDE;
      slave_ctl_ff <= `SSC_RST_SLAVE_CTL;
      dig_ctl_ff   <= `SSC_RST_DIG_CTL;
    end
    else if (wr_en)
    begin
      if (reg_addr_ff == `SSC_OFS_OBSERVE)
        obs_rsv_ff <= {rx_byte[7], rx_byte[1:0]};
      if (reg_addr_ff == `SSC_OFS_PD_MASK)
        pd_mask_ff <= rx_byte;
      if (reg_addr_ff == `SSC_OFS_OVERRIDE)
        override_ff <= rx_byte;
      if (reg_addr_ff == `SSC_OFS_SLAVE_CTL)
        slave_ctl_ff <= rx_byte;
      if (reg_addr_ff == `SSC_OFS_DIG_CTL)
        dig_ctl_ff <= rx_byte;
    end
  end

  // Idle counter.
  // The counter saturates so a long idle bus never wraps back to busy.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hi_cnt_ff     <= 10'h000;
      after_stop_ff <= 1'b1;
    end
    else
    begin
      hi_cnt_ff     <= !both_high ? 10'h000 : (high_done ? hi_cnt_ff : hi_cnt_ff + 10'h001);
      after_stop_ff <= stop_det || (after_stop_ff && !start_det);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      channel_power_down_ff    <= 8'h00;
      rx_detect_reset_ff       <= 1'b0;
      swing_eq_write_enable_ff <= 1'b0;
      bus_idle_ff              <= 1'b0;
    end
    else
    begin
      channel_power_down_ff    <= override_ff[`SSC_BIT_PD_OVR] ? pd_mask_ff : {8{pdpin_s2_ff}};
      rx_detect_reset_ff       <= override_ff[`SSC_BIT_RXD_OVR] ? override_ff[`SSC_BIT_RXD_VAL]
                                                                 : rx_detect_reset_auto;
      swing_eq_write_enable_ff <= slave_ctl_ff[`SSC_BIT_REG_EN];
      bus_idle_ff              <= buf_done || high_done;
    end
  end

  assign channel_power_down    = channel_power_down_ff;
  assign rx_detect_reset       = rx_detect_reset_ff;
  assign swing_eq_write_enable = swing_eq_write_enable_ff;
  assign bus_idle              = bus_idle_ff;
  assign bus.dev_sda_o         = 1'b0;
  assign bus.dev_sda_oe        = oe_ff;
endmodule : ssc_dev

// ---- verilog/ssc_host.sv ----
`timescale 1ns/1ps
module ssc_host
  import ssc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  ssc_if.host             bus,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata
);
  `include "ssc_map.svh"

  //////////////////////////////////////////////////////////////////////////////
  ssc_host_state_t state_ff, nxt_state;
  logic       q_ff;
  logic [1:0] ph_ff, nxt_ph;
  logic [3:0] bit_ff, nxt_bit;
  logic [1:0] byte_ff, nxt_byte;
  logic [7:0] txb_ff, nxt_txb, rxsh_ff, nxt_rxsh;
  logic       samp_ff, nxt_samp;
  logic       scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
  logic       sda_s1_ff, sda_s2_ff;
  logic [6:0] slave_ff;
  logic [7:0] reg_ff, wdat_ff, rdat_ff, nxt_rdat, rdata_ff;
  logic       read_ff, done_ff, nack_ff, set_done, set_nack;

  wire tick   = (q_ff == 1'(`SSC_QTR_CYC - 1));
  wire idle   = (state_ff == SSC_H_IDLE);
  wire go     = wr && (addr == `SSC_H_CTRL) && wdata[0] && idle;
  wire last_b = (ph_ff == 2'h3) && (bit_ff == 4'h8);

  // Byte index 0: address write, 1: register, 2: data or address read.
  function automatic logic [7:0] host_byte(input logic [1:0] i);
    return (i == 2'h0) ? {slave_ff, 1'b0} : (i == 2'h1) ? reg_ff
         : (read_ff ? {slave_ff, 1'b1} : wdat_ff);
  endfunction : host_byte

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_ph     = ph_ff;
    nxt_bit    = bit_ff;
    nxt_byte   = byte_ff;
    nxt_txb    = txb_ff;
    nxt_rxsh   = rxsh_ff;
    nxt_samp   = samp_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_rdat   = rdat_ff;
    set_done   = 1'b0;
    set_nack   = 1'b0;
    if (go)
    begin
      nxt_state = SSC_H_START;
      nxt_ph    = 2'h0;
      nxt_byte  = 2'h0;
    end
    else if (!idle && tick)
    begin
      nxt_ph = ph_ff + 2'h1;
      unique case (state_ff)
        SSC_H_START:
        begin
          nxt_sda_oe = (ph_ff >= 2'h2);
          // A repeated start holds the clock low one more quarter, so the slave lets go of its acknowledge first.
          nxt_scl_oe = (ph_ff == 2'h3) || ((ph_ff == 2'h0) && scl_oe_ff);
          if (ph_ff == 2'h3)
          begin
            nxt_state = SSC_H_TX;
            nxt_bit   = 4'h0;
            nxt_txb   = host_byte(byte_ff);
          end
        end
        SSC_H_TX, SSC_H_RX:
        begin
          // Data moves in phase 0 only, while the clock line is low.
          // Data under low clock.
          if (ph_ff == 2'h0)
            nxt_sda_oe = (state_ff == SSC_H_TX) && (bit_ff != 4'h8) && !txb_ff[7];
          if (ph_ff == 2'h1)
            nxt_scl_oe = 1'b0;
          if (ph_ff == 2'h2)
          begin
            nxt_samp = sda_s2_ff;
            if (bit_ff != 4'h8)
              nxt_rxsh = {rxsh_ff[6:0], sda_s2_ff};
          end
          if (ph_ff == 2'h3)
          begin
            nxt_scl_oe = 1'b1;
            nxt_bit    = bit_ff + 4'h1;
            nxt_txb    = {txb_ff[6:0], 1'b0};
          end
          if (last_b)
          begin
            nxt_bit = 4'h0;
            if (state_ff == SSC_H_TX && samp_ff)
            begin
              set_nack  = 1'b1;
              nxt_state = SSC_H_STOP;
            end
            else if (byte_ff == 2'h1 && read_ff)
            begin
              nxt_state = SSC_H_START;
              nxt_byte  = 2'h2;
            end
            else if (byte_ff == 2'h2 && read_ff)
            begin
              nxt_state = SSC_H_RX;
              nxt_byte  = 2'h3;
            end
            else if (byte_ff[1])
            begin
              nxt_state = SSC_H_STOP;
              if (byte_ff == 2'h3)
                nxt_rdat = rxsh_ff;
            end
            else
            begin
              nxt_byte = byte_ff + 2'h1;
              nxt_txb  = host_byte(byte_ff + 2'h1);
            end
          end
        end
        SSC_H_STOP:
        begin
          nxt_sda_oe = (ph_ff <= 2'h1);
          nxt_scl_oe = (ph_ff == 2'h0);
          if (ph_ff == 2'h3)
          begin
            nxt_state = SSC_H_IDLE;
            set_done  = 1'b1;
          end
        end
        default:
        begin
          nxt_state  = SSC_H_IDLE;
          nxt_scl_oe = 1'b0;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= SSC_H_IDLE;
      {q_ff, ph_ff, bit_ff, byte_ff} <= 9'h000;
      {txb_ff, rxsh_ff, rdat_ff}     <= 24'h000000;
      {samp_ff, scl_oe_ff, sda_oe_ff, sda_s1_ff, sda_s2_ff} <= 5'h03;
    end
    else
    begin
      state_ff  <= nxt_state;
      q_ff      <= (go || tick) ? 1'b0 : q_ff + 1'b1;
      ph_ff     <= nxt_ph;
      bit_ff    <= nxt_bit;
      byte_ff   <= nxt_byte;
      txb_ff    <= nxt_txb;
      rxsh_ff   <= nxt_rxsh;
      rdat_ff   <= nxt_rdat;
      samp_ff   <= nxt_samp;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      sda_s1_ff <= bus.sda;
      sda_s2_ff <= sda_s1_ff;
    end
  end

  // Command registers; parameters are locked while a transfer runs.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {slave_ff, read_ff, done_ff, nack_ff} <= 10'h000;
      {reg_ff, wdat_ff, rdata_ff}           <= 24'h000000;
    end
    else
    begin
      if (wr && idle && addr == `SSC_H_SLAVE)
        slave_ff <= wdata[6:0];
      if (wr && idle && addr == `SSC_H_REG)
        reg_ff <= wdata;
      if (wr && idle && addr == `SSC_H_WDATA)
        wdat_ff <= wdata;
      if (go)
        read_ff <= wdata[1];
      // A completion in the same cycle as a new start keeps its flag set.
      done_ff  <= set_done || (done_ff && !go);
      nack_ff  <= set_nack || (nack_ff && !go);
      rdata_ff <= !rd ? 8'h00
                : (addr == `SSC_H_STATUS) ? {5'h00, nack_ff, done_ff, !idle}
                : (addr == `SSC_H_RDATA) ? rdat_ff
                : (addr == `SSC_H_SLAVE) ? {1'b0, slave_ff}
                : (addr == `SSC_H_REG) ? reg_ff
                : (addr == `SSC_H_WDATA) ? wdat_ff : 8'h00;
    end
  end

  assign rdata           = rdata_ff;
  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe_ff;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = sda_oe_ff;
endmodule : ssc_host

// ---- tb/ssc_link_sva.sv ----
`timescale 1ns/1ps
module ssc_link_sva (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  logic [3:0] low_ff;

  // Counts clock-low cycles, saturating so a parked low clock cannot wrap.
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      low_ff <= 4'h0;
    else
      low_ff <= scl ? 4'h0 : ((low_ff == 4'hf) ? low_ff : low_ff + 4'h1);

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  //////////////////////////////////////////////////////////////////////////////
  ack_rise_a: assert property ($rose(dev_sda_oe) |-> !$past(scl))
    else $error("device pulled data while clock high");
  ack_fall_a: assert property ($fell(dev_sda_oe) |-> !$past(scl))
    else $error("device released data while clock high");
  hold_high_a: assert property (scl && $past(scl) && $past(scl, 2) |-> $stable(dev_sda_oe))
    else $error("device data moved during clock high");
  ack_bound_a: assert property ($rose(dev_sda_oe) |-> ##[1:80] !dev_sda_oe)
    else $error("device held data line too long");
  stop_release_a: assert property (scl && $past(scl) && $rose(sda) |=> !dev_sda_oe [*8])
    else $error("device drove data after stop");
  start_release_a: assert property (scl && $past(scl) && $fell(sda) |=> !dev_sda_oe [*8])
    else $error("device drove data during address");
  host_yield_a: assert property (dev_sda_oe && scl |-> !host_sda_oe)
    else $error("host drove data during device bit");
  low_time_a: assert property ($rose(scl) |-> low_ff >= 4'h3)
    else $error("clock low phase too short");
endmodule : ssc_link_sva

// ---- tb/ssc_tb.sv ----
`timescale 1ns/1ps
module ssc_tb;
  logic       clock = 1'b0;
  logic       reset_n = 1'b0;
  logic       serial_mode_strap = 1'b1;
  logic [3:0] addr_strap = 4'h0;
  logic       load_done = 1'b0;
  logic       pd_pin = 1'b0;
  logic       rxd_auto = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  wire  [7:0] rdata;
  wire  [7:0] pd;
  wire        rxd;
  wire        swe;
  wire        idle;
  logic [7:0] v;
  logic       nk;
  int         n_fail = 0;
  int         comparisons = 0;

  ssc_if bus_if ();
  always #50 clock = ~clock;

  ssc_dev i_ssc_dev (.clock(clock), .reset_n(reset_n), .bus(bus_if), .serial_mode_strap(serial_mode_strap),
    .addr_strap(addr_strap), .config_load_done(load_done), .power_down_pin(pd_pin),
    .rx_detect_reset_auto(rxd_auto), .channel_power_down(pd), .rx_detect_reset(rxd),
    .swing_eq_write_enable(swe), .bus_idle(idle));
  ssc_host i_ssc_host (.clock(clock), .reset_n(reset_n), .bus(bus_if), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  ssc_link_sva i_ssc_link_sva (.clock(clock), .reset_n(reset_n), .scl(bus_if.scl), .sda(bus_if.sda),
    .host_sda_oe(bus_if.host_sda_oe), .dev_sda_oe(bus_if.dev_sda_oe));

  //////////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task hw(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : hw

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task hr(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    @(negedge clock);
    d = rdata;
    @(posedge clock);
  endtask : hr

  task xfer(input logic [6:0] sa, input logic [7:0] ra, input logic [7:0] d, input logic r);
    hw(3'h1, {1'b0, sa});
    hw(3'h2, ra);
    hw(3'h3, d);
    hw(3'h0, {6'h00, r, 1'b1});
    v = 8'h00;
    for (int i = 0; i < 3000 && v[1] !== 1'b1; i++)
      hr(3'h4, v);
    chk("xfer_done", 8'h01, {7'h0, v[1]});
    nk = v[2];
    hr(3'h5, v);
  endtask : xfer

  task wreg(input logic [7:0] ra, input logic [7:0] d);
    xfer(7'h58 + {3'h0, addr_strap}, ra, d, 1'b0);
    chk("write_ack", 8'h00, {7'h0, nk});
  endtask : wreg

  task rreg(input logic [7:0] ra);
    xfer(7'h58 + {3'h0, addr_strap}, ra, 8'h00, 1'b1);
    chk("read_ack", 8'h00, {7'h0, nk});
  endtask : rreg

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk("swe_reset", 8'h00, {7'h0, swe});
    // every strap value, plus a wrong address.
    for (int s = 0; s < 16; s++)
    begin
      addr_strap <= s[3:0];
      load_done  <= s[0];
      repeat (6) @(posedge clock);
      rreg(8'h00);
      chk("observe", {1'b0, s[3:0], s[0], 2'b00}, v);
      xfer(7'h58 + {3'h0, ~s[3:0]}, 8'h01, 8'hff, 1'b0);
      chk("miss_nack", 8'h01, {7'h0, nk});
    end
    // mask reset then write and read back.
    rreg(8'h01);
    chk("mask_reset", 8'h00, v);
    wreg(8'h01, 8'ha5);
    rreg(8'h01);
    chk("mask_read", 8'ha5, v);
    chk("pd_pin_ctl", 8'h00, pd);
    // pin against register control; reserved bits written as zero.
    pd_pin <= 1'b1;
    wreg(8'h02, 8'h01);
    chk("pd_reg_ctl", 8'ha5, pd);
    wreg(8'h02, 8'h00);
    chk("pd_pin_on", 8'hff, pd);
    wreg(8'h02, 8'hc0);
    chk("rxd_set", 8'h01, {7'h0, rxd});
    rxd_auto <= 1'b1;
    wreg(8'h02, 8'h80);
    chk("rxd_clr", 8'h00, {7'h0, rxd});
    wreg(8'h02, 8'h00);
    chk("rxd_auto", 8'h01, {7'h0, rxd});
    wreg(8'h06, 8'h18);
    chk("swe_on", 8'h01, {7'h0, swe});
    wreg(8'h07, 8'h40);
    chk("swe_back", 8'h00, {7'h0, swe});
    rreg(8'h07);
    chk("soft_clear", 8'h01, v);
    rreg(8'h01);
    chk("mask_default", 8'h00, v);
    repeat (60) @(posedge clock);
    chk("bus_idle", 8'h01, {7'h0, idle});
    // slave disabled by the mode strap.
    serial_mode_strap <= 1'b0;
    repeat (6) @(posedge clock);
    xfer(7'h58 + {3'h0, addr_strap}, 8'h01, 8'h33, 1'b0);
    chk("mode_nack", 8'h01, {7'h0, nk});
    serial_mode_strap <= 1'b1;
    repeat (6) @(posedge clock);
    rreg(8'h01);
    chk("mode_nowrite", 8'h00, v);
    finish_test();
  end

  // About fifty transfers of some three hundred cycles each fit well inside this.
  initial
  begin
    #6000000;
    n_fail++;
    finish_test();
  end
endmodule : ssc_tb
